// ===== verilog/dss_defines.svh
// Offsets, field positions, widths and constants of the sequencer status block
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

`define DSS_ADDR_W 12
`define DSS_STATUS_OFFSET 12'h02ec
`define DSS_STATUS_RESET 32'h0000_0000

`define DSS_BIT_DMA_TERM 20
`define DSS_BIT_DMA_ERR 18
`define DSS_BIT_DMA_BUSY 17
`define DSS_BIT_DMA_IDLE 16
`define DSS_BIT_FRAME_ERR 6
`define DSS_BIT_TIMING_ERR 5
`define DSS_BIT_UNDERRUN_ERR 4
`define DSS_BIT_CONV_ACTIVE 2
`define DSS_BIT_LOADED 1
`define DSS_BIT_OUTPUT_UNIT_QUIET_FLAG 0

`define DSS_NUM_DACS 2
`define DSS_CHANS 4
`define DSS_CNT_W 28
`define DSS_CNT_ZERO 28'h000_0000
`define DSS_CNT_ONE 28'h000_0001
`define DSS_CHAN_ALL 4'hf
`define DSS_CHAN_NONE 4'h0

`endif

// ===== verilog/dss_pkg.sv
// Types shared by the sequencer status modules
package dss_pkg;

    typedef enum logic [1:0] {
        dss_ou_off  = 2'b00,
        dss_output_unit_quiet_flag = 2'b01,
        dss_ou_run  = 2'b10,
        dss_ou_halt = 2'b11
    } dss_ou_state_e;

    typedef enum logic [1:0] {
        dss_dma_off  = 2'b00,
        dss_dma_idle = 2'b01,
        dss_dma_busy = 2'b10,
        dss_dma_halt = 2'b11
    } dss_dma_state_e;

endpackage

// ===== verilog/dss_dma_if.sv
// DMA controller status carried from the DMA tracker to the status register
interface dss_dma_if;
    logic busy;
    logic idle;
    logic term;
    logic err;

    modport dma (output busy, output idle, output term, output err);
    modport top (input busy, input idle, input term, input err);
endinterface

// ===== verilog/dss_dma.sv
// Read-direction DMA controller state and its status flags
`include "dss_defines.svh"

module dss_dma (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic dma_enable,
    input wire logic buf_len_wr,
    input wire logic [`DSS_CNT_W-1:0] buf_len,
    input wire logic fifo_push,
    input wire logic master_abort,
    input wire logic target_abort,
    output logic dma_run,
    dss_dma_if.dma st
);
    dss_pkg::dss_dma_state_e state;
    logic [`DSS_CNT_W-1:0] remaining;
    logic term;
    logic err;
    logic start;
    logic last_push;
    logic abort;

    assign start = (state == dss_pkg::dss_dma_idle) && buf_len_wr;
    assign last_push = (state == dss_pkg::dss_dma_busy) && fifo_push
        && (remaining == `DSS_CNT_ONE);
    assign abort = (state == dss_pkg::dss_dma_busy) && (master_abort || target_abort);

    // ---------------------------------------------------------------
    // Controller state
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst || !dma_enable) begin
            state <= dss_pkg::dss_dma_off;
        end else if (state == dss_pkg::dss_dma_off) begin
            state <= dss_pkg::dss_dma_idle;
        end else if (abort) begin
            state <= dss_pkg::dss_dma_halt;
        end else if (start && buf_len != `DSS_CNT_ZERO) begin
            state <= dss_pkg::dss_dma_busy;
        end else if (last_push) begin
            state <= dss_pkg::dss_dma_idle;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            remaining <= `DSS_CNT_ZERO;
        end else if (start) begin
            remaining <= buf_len;
        end else if (state == dss_pkg::dss_dma_busy && fifo_push) begin
            remaining <= remaining - `DSS_CNT_ONE;
        end
    end

    // ---------------------------------------------------------------
    // Flags
    // ---------------------------------------------------------------
    // An empty buffer counts as fully fetched at once
    always_ff @(posedge core_clk) begin
        if (srst) begin
            term <= 1'b0;
        end else if (last_push || (start && buf_len == `DSS_CNT_ZERO)) begin
            term <= 1'b1;
        end else if (buf_len_wr) begin
            term <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !dma_enable) begin
            err <= 1'b0;
        end else if (abort) begin
            err <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dma_run <= 1'b0;
        end else begin
            dma_run <= (state == dss_pkg::dss_dma_busy) && !abort && !last_push && dma_enable;
        end
    end

    assign st.busy = (state == dss_pkg::dss_dma_busy);
    assign st.idle = (state == dss_pkg::dss_dma_idle);
    assign st.term = term;
    assign st.err = err;
endmodule // dss_dma

// ===== verilog/dss_dacs_loaded_flag.sv
// Tracks which sequencer DACs hold fresh data on every channel
`include "dss_defines.svh"

module dss_dacs_loaded_flag (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic ou_enable,
    input wire logic [`DSS_NUM_DACS-1:0] dac_in_seq,
    input wire logic [`DSS_NUM_DACS*`DSS_CHANS-1:0] chan_load,
    input wire logic conv_fire,
    input wire logic unload,
    output logic all_loaded
);
    logic [`DSS_NUM_DACS*`DSS_CHANS-1:0] fresh;
    logic [`DSS_NUM_DACS-1:0] dac_ready;

    function automatic logic dac_full(input logic [`DSS_CHANS-1:0] chans);
        dac_full = (chans == `DSS_CHAN_ALL);
    endfunction

    // ---------------------------------------------------------------
    // Per-DAC channel freshness
    // ---------------------------------------------------------------
    genvar d;
    generate
        for (d = 0; d < `DSS_NUM_DACS; d = d + 1) begin : g_dac
            // A load that lands with the conversion pulse belongs to the next conversion
            always_ff @(posedge core_clk) begin
                if (srst || !ou_enable) begin
                    fresh[d*`DSS_CHANS +: `DSS_CHANS] <= `DSS_CHAN_NONE;
                end else if (conv_fire || unload) begin
                    fresh[d*`DSS_CHANS +: `DSS_CHANS] <= chan_load[d*`DSS_CHANS +: `DSS_CHANS];
                end else begin
                    fresh[d*`DSS_CHANS +: `DSS_CHANS] <= fresh[d*`DSS_CHANS +: `DSS_CHANS]
                        | chan_load[d*`DSS_CHANS +: `DSS_CHANS];
                end
            end
            assign dac_ready[d] = !dac_in_seq[d] || dac_full(fresh[d*`DSS_CHANS +: `DSS_CHANS]);
        end
    endgenerate

    // With no DAC assigned the flag stays low
    always_ff @(posedge core_clk) begin
        if (srst || !ou_enable || conv_fire || unload) begin
            all_loaded <= 1'b0;
        end else begin
            all_loaded <= (&dac_ready) && (|dac_in_seq);
        end
    end
endmodule // dss_dacs_loaded_flag

// ===== verilog/dss_top.sv
// Sequencer status register with output unit pacing and error tracking
`include "dss_defines.svh"

module dss_top (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reg_rd_en,
    input wire logic reg_wr_en,
    input wire logic [`DSS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic output_unit_on_bit,
    input wire logic pacing_select_bit,
    input wire logic conversion_go_bit,
    input wire logic unload_dacs_bit,
    input wire logic [`DSS_CNT_W-1:0] num_conv,
    input wire logic conv_clk_tick,
    input wire logic frame_trigger_pin,
    input wire logic [`DSS_NUM_DACS-1:0] dac_refusing,
    input wire logic [`DSS_NUM_DACS-1:0] dac_in_seq,
    input wire logic [`DSS_NUM_DACS*`DSS_CHANS-1:0] chan_load,
    output logic dac_conv_pulse,
    input wire logic dma_enable,
    input wire logic buf_len_wr,
    input wire logic [`DSS_CNT_W-1:0] buf_len,
    input wire logic fifo_push,
    input wire logic master_abort,
    input wire logic target_abort,
    output logic dma_run
);
    dss_dma_if dma_st ();

    dss_pkg::dss_ou_state_e ou_state;
    logic [`DSS_CNT_W-1:0] conv_count;
    logic frame_overrun_flag;
    logic timing_err;
    logic underrun_err;
    logic conversion_running_flag;
    logic dacs_loaded_flag;
    logic output_unit_quiet_flag;
    logic trig_meta;
    logic trig_sync;
    logic trig_prev;
    logic frame_trig;
    logic in_run;
    logic frame_mode;
    logic trig_early;
    logic refuse_hit;
    logic underrun_hit;
    logic conv_fire;
    logic last_conv;
    logic [31:0] status_word;

    // ---------------------------------------------------------------
    // Submodules
    // ---------------------------------------------------------------
    dss_dma u_dma (
        .core_clk(core_clk),
        .srst(srst),
        .dma_enable(dma_enable),
        .buf_len_wr(buf_len_wr),
        .buf_len(buf_len),
        .fifo_push(fifo_push),
        .master_abort(master_abort),
        .target_abort(target_abort),
        .dma_run(dma_run),
        .st(dma_st)
    );

    dss_dacs_loaded_flag u_dacs_loaded_flag (
        .core_clk(core_clk),
        .srst(srst),
        .ou_enable(output_unit_on_bit),
        .dac_in_seq(dac_in_seq),
        .chan_load(chan_load),
        .conv_fire(conv_fire),
        .unload(unload_dacs_bit),
        .all_loaded(dacs_loaded_flag)
    );

    // ---------------------------------------------------------------
    // Frame trigger pin
    // ---------------------------------------------------------------
    // Two stages before the edge detector; the pin is asynchronous
    always_ff @(posedge core_clk) begin
        if (srst) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            trig_meta <= frame_trigger_pin;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    assign frame_trig = trig_sync && !trig_prev;

    // ---------------------------------------------------------------
    // Conversion decisions
    // ---------------------------------------------------------------
    assign frame_mode = pacing_select_bit;
    assign in_run = (ou_state == dss_pkg::dss_ou_run);
    assign trig_early = in_run && frame_mode && frame_trig;
    assign refuse_hit = in_run && !trig_early && conv_clk_tick && (|(dac_refusing & dac_in_seq));
    assign underrun_hit = in_run && !trig_early && conv_clk_tick && !refuse_hit
        && !dacs_loaded_flag;
    // No pulse once any error is seen in the same cycle
    assign conv_fire = in_run && conv_clk_tick && !trig_early && !refuse_hit
        && !underrun_hit;
    assign last_conv = conv_fire && (num_conv != `DSS_CNT_ZERO)
        && ((conv_count + `DSS_CNT_ONE) == num_conv);

    // ---------------------------------------------------------------
    // Output unit state
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            ou_state <= dss_pkg::dss_ou_off;
        end else begin
            case (ou_state)
                dss_pkg::dss_ou_off: begin
                    ou_state <= dss_pkg::dss_output_unit_quiet_flag;
                end
                dss_pkg::dss_output_unit_quiet_flag: begin
                    if (!frame_mode && conversion_go_bit) begin
                        ou_state <= dss_pkg::dss_ou_run;
                    end else if (frame_mode && frame_trig) begin
                        ou_state <= dss_pkg::dss_ou_run;
                    end
                end
                dss_pkg::dss_ou_run: begin
                    if (trig_early || refuse_hit || underrun_hit) begin
                        ou_state <= dss_pkg::dss_ou_halt;
                    end else if (last_conv) begin
                        ou_state <= dss_pkg::dss_output_unit_quiet_flag;
                    end
                end
                dss_pkg::dss_ou_halt: begin
                    ou_state <= dss_pkg::dss_ou_halt;
                end
                default: begin
                    ou_state <= dss_pkg::dss_ou_off;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            conv_count <= `DSS_CNT_ZERO;
        end else if (ou_state == dss_pkg::dss_output_unit_quiet_flag
            && ((!frame_mode && conversion_go_bit) || (frame_mode && frame_trig))) begin
            conv_count <= `DSS_CNT_ZERO;
        end else if (conv_fire) begin
            conv_count <= conv_count + `DSS_CNT_ONE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dac_conv_pulse <= 1'b0;
        end else begin
            dac_conv_pulse <= conv_fire && output_unit_on_bit;
        end
    end

    // ---------------------------------------------------------------
    // Output unit flags
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            frame_overrun_flag <= 1'b0;
        end else if (trig_early) begin
            frame_overrun_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            timing_err <= 1'b0;
        end else if (refuse_hit) begin
            timing_err <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            underrun_err <= 1'b0;
        end else if (underrun_hit) begin
            underrun_err <= 1'b1;
        end
    end

    // An early trigger never marks the frame active
    always_ff @(posedge core_clk) begin
        if (srst || !output_unit_on_bit) begin
            conversion_running_flag <= 1'b0;
        end else if (ou_state == dss_pkg::dss_output_unit_quiet_flag && !frame_mode && conversion_go_bit) begin
            conversion_running_flag <= 1'b1;
        end else if (ou_state == dss_pkg::dss_output_unit_quiet_flag && frame_mode && frame_trig) begin
            conversion_running_flag <= 1'b1;
        end else if (last_conv || trig_early || refuse_hit || underrun_hit) begin
            conversion_running_flag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            output_unit_quiet_flag <= 1'b0;
        end else begin
            output_unit_quiet_flag <= output_unit_on_bit
                && (ou_state == dss_pkg::dss_output_unit_quiet_flag);
        end
    end

    // ---------------------------------------------------------------
    // Status register read
    // ---------------------------------------------------------------
    always_comb begin
        status_word = `DSS_STATUS_RESET;
        status_word[`DSS_BIT_DMA_TERM] = dma_st.term;
        status_word[`DSS_BIT_DMA_ERR] = dma_st.err;
        status_word[`DSS_BIT_DMA_BUSY] = dma_st.busy;
        status_word[`DSS_BIT_DMA_IDLE] = dma_st.idle;
        status_word[`DSS_BIT_FRAME_ERR] = frame_overrun_flag;
        status_word[`DSS_BIT_TIMING_ERR] = timing_err;
        status_word[`DSS_BIT_UNDERRUN_ERR] = underrun_err;
        status_word[`DSS_BIT_CONV_ACTIVE] = conversion_running_flag;
        status_word[`DSS_BIT_LOADED] = dacs_loaded_flag;
        status_word[`DSS_BIT_OUTPUT_UNIT_QUIET_FLAG] = output_unit_quiet_flag;
    end

    // Writes to this read-only register are accepted and dropped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= `DSS_STATUS_RESET;
            reg_rd_valid <= 1'b0;
        end else if (reg_rd_en && reg_addr == `DSS_STATUS_OFFSET) begin
            reg_rdata <= status_word;
            reg_rd_valid <= 1'b1;
        end else if (reg_rd_en) begin
            reg_rdata <= `DSS_STATUS_RESET;
            reg_rd_valid <= 1'b1;
        end else begin
            reg_rdata <= `DSS_STATUS_RESET;
            reg_rd_valid <= 1'b0;
        end
    end

    logic unused_wr;
    assign unused_wr = reg_wr_en ^ (|reg_wdata);
endmodule // dss_top

// ===== test/dss_checker.sv
// Assertion checker for the sequencer status block, bound to its top module
`include "dss_defines.svh"

module dss_checker (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reg_rd_en,
    input wire logic [`DSS_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic output_unit_on_bit,
    input wire logic conv_clk_tick,
    input wire logic dac_conv_pulse,
    input wire logic dma_enable,
    input wire logic master_abort,
    input wire logic target_abort,
    input wire logic dma_run
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    rd_quiet_a: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rdata == 32'h0000_0000)
        else $error("read data without a read");
    rsvd_zero_a: assert property (reg_rd_valid |-> (reg_rdata & 32'hffe8_ff88) == 32'h0000_0000)
        else $error("reserved status bit set");
    unmapped_zero_a: assert property (reg_rd_en && reg_addr != `DSS_STATUS_OFFSET
        |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
    pulse_cause_a: assert property (dac_conv_pulse |-> $past(conv_clk_tick)
        && $past(output_unit_on_bit)) else $error("conversion pulse without tick");
    off_quiet_a: assert property (!output_unit_on_bit |=> !dac_conv_pulse [*2])
        else $error("pulse while output unit off");
    busy_idle_a: assert property (reg_rd_valid |-> !(reg_rdata[17] && reg_rdata[16]))
        else $error("dma busy and idle together");
    err_halt_a: assert property (reg_rd_valid && reg_rdata[18] |-> reg_rdata[17:16] == 2'h0)
        else $error("dma error without halt");
    abort_stop_a: assert property (dma_run && (master_abort || target_abort)
        |-> ##[1:2] !dma_run) else $error("dma runs on after abort");
    dma_off_a: assert property (!dma_enable |=> !dma_run)
        else $error("dma runs while disabled");
    ou_err_stop_a: assert property (reg_rd_valid && reg_rdata[6:4] != 3'h0
        |-> !reg_rdata[2] && !reg_rdata[0]) else $error("output unit active after error");

    cover property (dac_conv_pulse);
    cover property (reg_rd_valid && reg_rdata[18]);
    cover property (reg_rd_valid && reg_rdata[6]);
endmodule // dss_checker

bind dss_top dss_checker i_dss_checker (
    .core_clk(core_clk), .srst(srst), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .output_unit_on_bit(output_unit_on_bit),
    .conv_clk_tick(conv_clk_tick), .dac_conv_pulse(dac_conv_pulse), .dma_enable(dma_enable),
    .master_abort(master_abort), .target_abort(target_abort), .dma_run(dma_run)
);

// ===== test/dss_host_mem.sv
// Host memory model feeding the read DMA, with wait states and aborts
module dss_host_mem (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic dma_run,
    input wire logic slow,
    input wire logic abort_go,
    input wire logic target_kind,
    output logic fifo_push,
    output logic master_abort,
    output logic target_abort
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Fetch pacing and bus faults
    // ----------------------------------------
    logic [1:0] pace;

    always_ff @(posedge core_clk) begin
        pace <= (srst || !dma_run) ? 2'h0 : pace + 2'h1;
    end

    // One value per fetch; slow mode stretches each fetch to four cycles
    always_ff @(posedge core_clk) begin
        fifo_push <= !srst && dma_run && !abort_go && (!slow || pace == 2'h3);
    end

    // Fault only lands on a live burst, as a real bus would report it
    always_ff @(posedge core_clk) begin
        master_abort <= !srst && abort_go && dma_run && !target_kind;
        target_abort <= !srst && abort_go && dma_run && target_kind;
    end
endmodule // dss_host_mem

// ===== test/dac_sequencer_status_tb.sv
// Self-checking bench for the sequencer status block
`include "dss_defines.svh"

module dac_sequencer_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and status masks
    // ----------------------------------------
    localparam logic [31:0] trm = 32'h0010_0000;
    localparam logic [31:0] derr = 32'h0004_0000;
    localparam logic [31:0] bsy = 32'h0002_0000;
    localparam logic [31:0] did = 32'h0001_0000;
    localparam logic [31:0] dmsk = 32'h0017_0000;
    localparam logic [31:0] fer = 32'h0000_0040;
    localparam logic [31:0] ter = 32'h0000_0020;
    localparam logic [31:0] uer = 32'h0000_0010;
    localparam logic [31:0] act = 32'h0000_0004;
    localparam logic [31:0] lod = 32'h0000_0002;
    localparam logic [31:0] oid = 32'h0000_0001;
    localparam logic [31:0] oumsk = 32'h0000_0073;
    localparam int go = 0;
    localparam int unl = 1;
    localparam int blw = 2;
    localparam int abt = 3;
    logic core_clk, srst, reg_rd_en, reg_wr_en, reg_rd_valid, output_unit_on_bit;
    logic pacing_select_bit, conversion_go_bit, unload_dacs_bit, conv_clk_tick;
    logic frame_trigger_pin, dac_conv_pulse, dma_enable, buf_len_wr, fifo_push;
    logic master_abort, target_abort, dma_run, slow, abort_go, target_kind;
    logic [`DSS_ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rdw;
    logic [1:0] dac_refusing, dac_in_seq;
    logic [7:0] chan_load;
    logic [27:0] num_conv, buf_len;
    int n_errors, n_checks, k;

    dss_top i_dss_top (
        .core_clk(core_clk), .srst(srst), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .output_unit_on_bit(output_unit_on_bit),
        .pacing_select_bit(pacing_select_bit), .conversion_go_bit(conversion_go_bit),
        .unload_dacs_bit(unload_dacs_bit), .num_conv(num_conv), .conv_clk_tick(conv_clk_tick),
        .frame_trigger_pin(frame_trigger_pin), .dac_refusing(dac_refusing),
        .dac_in_seq(dac_in_seq), .chan_load(chan_load), .dac_conv_pulse(dac_conv_pulse),
        .dma_enable(dma_enable), .buf_len_wr(buf_len_wr), .buf_len(buf_len),
        .fifo_push(fifo_push), .master_abort(master_abort), .target_abort(target_abort),
        .dma_run(dma_run)
    );

    dss_host_mem i_dss_host_mem (
        .core_clk(core_clk), .srst(srst), .dma_run(dma_run), .slow(slow), .abort_go(abort_go),
        .target_kind(target_kind), .fifo_push(fifo_push), .master_abort(master_abort),
        .target_abort(target_abort)
    );

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [`DSS_ADDR_W-1:0] a, output logic [31:0] d);
        reg_rd_en = 1'b1;
        reg_addr = a;
        cyc(1);
        reg_rd_en = 1'b0;
        chk({31'h0000_0000, reg_rd_valid}, 32'h0000_0001);
        d = reg_rdata;
    endtask

    task automatic rs(input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        rd(`DSS_STATUS_OFFSET, d);
        chk(d & m, e);
    endtask

    // Pulse strobes are one cycle wide, matching the self-clearing control bits
    task automatic pl(input int w);
        case (w)
            go: conversion_go_bit = 1'b1;
            unl: unload_dacs_bit = 1'b1;
            blw: buf_len_wr = 1'b1;
            default: abort_go = 1'b1;
        endcase
        cyc(1);
        {conversion_go_bit, unload_dacs_bit, buf_len_wr, abort_go} = 4'h0;
    endtask

    // The loaded flag is registered one edge after the channel freshness it reflects
    task automatic ld(input logic [7:0] v);
        chan_load = v;
        cyc(1);
        chan_load = 8'h00;
        cyc(1);
    endtask

    task automatic tk(input logic e);
        conv_clk_tick = 1'b1;
        cyc(1);
        conv_clk_tick = 1'b0;
        chk({31'h0000_0000, dac_conv_pulse}, {31'h0000_0000, e});
    endtask

    // Pin held long enough to pass the synchroniser, then low so the next rise counts
    task automatic trg;
        frame_trigger_pin = 1'b1;
        cyc(5);
        frame_trigger_pin = 1'b0;
        cyc(4);
    endtask

    task automatic ou_rst;
        output_unit_on_bit = 1'b0;
        cyc(2);
        rs(oumsk, 32'h0000_0000);
        output_unit_on_bit = 1'b1;
        cyc(2);
    endtask

    task automatic dwait;
        for (int i = 0; i < 100 && dma_run !== 1'b0; i++) cyc(1);
        cyc(2);
    endtask

    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {srst, reg_rd_en, reg_wr_en, reg_addr, reg_wdata} = {3'h4, 44'h0};
        {output_unit_on_bit, pacing_select_bit, conversion_go_bit, unload_dacs_bit} = 4'h0;
        {conv_clk_tick, frame_trigger_pin, dma_enable, buf_len_wr, slow, abort_go} = 6'h00;
        {target_kind, dac_refusing, dac_in_seq, chan_load} = {1'b0, 2'h0, 2'h1, 8'h00};
        num_conv = 28'h000_0002;
        buf_len = 28'h000_0000;
        cyc(16);
        srst = 1'b0;
        cyc(2);
        rs(32'hffff_ffff, 32'h0000_0000);
        {output_unit_on_bit, dma_enable} = 2'h3;
        cyc(2);
        rs(32'hffff_ffff, did | oid);
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, `DSS_STATUS_OFFSET, 32'hffff_ffff};
        cyc(1);
        reg_wr_en = 1'b0;
        rs(32'hffff_ffff, did | oid);
        rd(12'h2f0, rdw);
        chk(rdw, 32'h0000_0000);
        pl(blw);
        cyc(1);
        rs(dmsk, trm | did);
        for (k = 0; k < 2; k++) begin
            slow = k[0];
            buf_len = 28'h000_0003 + 28'(k);
            pl(blw);
            rs(trm | bsy | did, bsy);
            cyc(2);
            dwait();
            rs(dmsk, trm | did);
        end
        for (k = 0; k < 2; k++) begin
            {slow, target_kind, buf_len} = {1'b1, k[0], 28'h000_0008};
            pl(blw);
            cyc(3);
            pl(abt);
            cyc(1);
            rs(derr | bsy | did, derr);
            pl(blw);
            cyc(2);
            rs(derr | bsy | did, derr);
            dma_enable = 1'b0;
            cyc(2);
            rs(dmsk, 32'h0000_0000);
            dma_enable = 1'b1;
            cyc(2);
            rs(derr | bsy | did, did);
        end
        for (k = 0; k < 3; k++) ld(8'h01 << k);
        rs(lod, 32'h0000_0000);
        ld(8'h08);
        rs(lod, lod);
        pl(unl);
        rs(lod, 32'h0000_0000);
        dac_in_seq = 2'h3;
        ld(8'h0f);
        rs(lod, 32'h0000_0000);
        ld(8'hf0);
        rs(lod, lod);
        pl(go);
        cyc(1);
        rs(act | oid, act);
        tk(1'b1);
        rs(lod, 32'h0000_0000);
        ld(8'hff);
        tk(1'b1);
        cyc(1);
        rs(act | oid | lod, oid);
        trg();
        rs(act | oid, oid);
        pl(go);
        tk(1'b0);
        rs(uer | act | oid, uer);
        ld(8'hff);
        tk(1'b0);
        ou_rst();
        ld(8'hff);
        dac_refusing = 2'h2;
        pl(go);
        tk(1'b0);
        rs(ter | act, ter);
        dac_refusing = 2'h0;
        ou_rst();
        pacing_select_bit = 1'b1;
        ld(8'hff);
        trg();
        rs(act | fer, act);
        tk(1'b1);
        ld(8'hff);
        trg();
        rs(fer | act | oid, fer);
        tk(1'b0);
        ou_rst();
        ld(8'hff);
        trg();
        tk(1'b1);
        ld(8'hff);
        tk(1'b1);
        cyc(1);
        rs(act | oid, oid);
        print_verdict();
    end
endmodule // dac_sequencer_status_tb
